/* File: verilog/acs_pkg.sv */
package acs_pkg;

  // ==========================================================
  // converter timing; CAL_CYCLES and POST_CAL_CYCLES in converter clock cycles, CONV_DIV and START_GAP in core clock cycles
  localparam int CAL_CYCLES      = 3840;
  localparam int CONV_DIV        = 4;
  localparam int POST_CAL_CYCLES = 2;
  localparam int START_GAP       = 2;

  // ==========================================================
  // widths and calibration store
  localparam int RESULT_W  = 12;
  localparam int CHAN_W    = 5;
  localparam int STC_W     = 8;
  localparam int TRIM_W    = 8;
  localparam int CAL_SLOTS = 13;
  localparam int SLOT_W    = 4;
  localparam logic [TRIM_W-1:0] TRIM_RESET = 8'h80;
  localparam logic [TRIM_W-1:0] TRIM_MAX   = 8'hFF;
  localparam logic [TRIM_W-1:0] TRIM_MIN   = 8'h00;

  // ==========================================================
  // resolution codes
  localparam logic [1:0] RES_8   = 2'h0;
  localparam logic [1:0] RES_10  = 2'h1;
  localparam logic [1:0] RES_12  = 2'h2;
  localparam logic [3:0] BITS_8  = 4'h8;
  localparam logic [3:0] BITS_10 = 4'hA;
  localparam logic [3:0] BITS_12 = 4'hC;

  function automatic logic [3:0] res_bits(input logic [1:0] r);
    case (r)
      RES_8:   res_bits = BITS_8;
      RES_10:  res_bits = BITS_10;
      default: res_bits = BITS_12;
    endcase
  endfunction

  function automatic logic [RESULT_W-1:0] res_mask(input logic [1:0] r);
    res_mask = 12'hFFF << (BITS_12 - res_bits(r));
  endfunction

  // ==========================================================
  // register map, byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_CFG    = 8'h04;
  localparam logic [7:0] REG_STC    = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RESULT = 8'h10;

  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_CRST_BIT  = 1;
  localparam int CFG_RES_LSB    = 0;
  localparam int CFG_POST_BIT   = 3;
  localparam int CFG_CHAN_LSB   = 8;
  localparam int ST_SAMPLE_BIT  = 0;
  localparam int ST_BUSY_BIT    = 1;
  localparam int ST_READY_BIT   = 2;
  localparam int ST_CAL_BIT     = 3;
  localparam int ST_FRESH_BIT   = 4;
  localparam int RES_FRESH_BIT  = 16;

  localparam logic [1:0]       CFG_RES_RESET  = RES_12;
  localparam logic             CFG_POST_RESET = 1'b1;
  localparam logic [STC_W-1:0] STC_RESET      = 8'h04;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // sequencer states
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_SAMPLE = 4'b0010,
    ST_DIST   = 4'b0100,
    ST_POST   = 4'b1000
  } acs_state_t;

endpackage

/* File: verilog/acs_if.sv */
interface acs_if;

  // ==========================================================
  // requests from user logic
  logic                         conversion_start;
  logic [acs_pkg::CHAN_W-1:0]   channel_select;
  logic [acs_pkg::STC_W-1:0]    sample_time_field;
  logic                         post_cal_enable;
  logic [1:0]                   resolution_select;
  logic                         converter_reset;

  // ==========================================================
  // status from the converter
  logic                         sampling;
  logic                         busy;
  logic                         result_ready;
  logic [acs_pkg::RESULT_W-1:0] result;
  logic                         calibrating;

  modport dev (
    input  conversion_start, channel_select, sample_time_field,
    input  post_cal_enable, resolution_select, converter_reset,
    output sampling, busy, result_ready, result, calibrating
  );

  modport usr (
    output conversion_start, channel_select, sample_time_field,
    output post_cal_enable, resolution_select, converter_reset,
    input  sampling, busy, result_ready, result, calibrating
  );

endinterface

/* File: verilog/acs_device.sv */
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
module acs_device #(
  parameter int CAL_CYCLES = acs_pkg::CAL_CYCLES,
  parameter int CONV_DIV   = acs_pkg::CONV_DIV
) (
  // clock and reset
  input  wire logic                         CORE_CLK_I,
  input  wire logic                         RESET_N_I,
  // link to user logic
  acs_if.dev                                LINK,
  // analog front end
  input  wire logic [acs_pkg::RESULT_W-1:0] SAMPLE_VALUE_I,
  input  wire logic                         CAL_CMP_I,
  output logic      [acs_pkg::CHAN_W-1:0]   CHANNEL_O,
  output logic      [acs_pkg::TRIM_W-1:0]   CAL_TRIM_O
);

  // ==========================================================
  // declarations
  acs_pkg::acs_state_t            state;
  logic                           start_q;
  logic [7:0]                     div_cnt;
  logic                           tick;
  logic [8:0]                     ph_cnt;
  logic [acs_pkg::STC_W-1:0]      stc_q;
  logic                           post_q;
  logic [1:0]                     res_q;
  logic [acs_pkg::RESULT_W-1:0]   held;
  logic [acs_pkg::RESULT_W-1:0]   result;
  logic                           result_ready;
  logic                           cal_busy;
  logic [15:0]                    cal_cnt;
  logic [acs_pkg::SLOT_W-1:0]     slot;
  logic [acs_pkg::TRIM_W-1:0]     trim [acs_pkg::CAL_SLOTS];
  logic                           sample_end;
  logic                           dist_end;
  logic                           post_end;
  logic                           run;
  logic                           done;
  logic                           trim_step_en;

  // ==========================================================
  // helpers
  function automatic logic [acs_pkg::SLOT_W-1:0] next_slot(input logic [acs_pkg::SLOT_W-1:0] s);
    if (s == acs_pkg::SLOT_W'(acs_pkg::CAL_SLOTS - 1)) begin
      next_slot = '0;
    end else begin
      next_slot = s + 1'b1;
    end
  endfunction

  function automatic logic [acs_pkg::TRIM_W-1:0] trim_step(input logic [acs_pkg::TRIM_W-1:0] v,
                                                           input logic cmp);
    if (cmp) begin
      trim_step = (v == acs_pkg::TRIM_MIN) ? v : v - 1'b1;
    end else begin
      trim_step = (v == acs_pkg::TRIM_MAX) ? v : v + 1'b1;
    end
  endfunction

  // ==========================================================
  // start synchroniser stage
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      start_q <= 1'b0;
    end else begin
      start_q <= LINK.conversion_start;
    end
  end

  // ==========================================================
  // converter clock divider, realigned on each start
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      div_cnt <= '0;
    end else if (start_q || tick) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  assign tick = (div_cnt == 8'(CONV_DIV - 1));

  // ==========================================================
  // phase end conditions
  assign run        = tick && !start_q && !LINK.converter_reset;
  assign sample_end = (ph_cnt == {1'b0, stc_q});
  assign dist_end   = (ph_cnt == 9'(acs_pkg::res_bits(res_q) - 1'b1));
  assign post_end   = (ph_cnt == 9'(acs_pkg::POST_CAL_CYCLES - 1));
  assign done       = run && (((state == acs_pkg::ST_DIST) && dist_end && !post_q) ||
                              ((state == acs_pkg::ST_POST) && post_end));

  // ==========================================================
  // configuration captured at start
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      stc_q     <= acs_pkg::STC_RESET;
      post_q    <= acs_pkg::CFG_POST_RESET;
      res_q     <= acs_pkg::CFG_RES_RESET;
      CHANNEL_O <= '0;
    end else if (start_q) begin
      stc_q     <= LINK.sample_time_field;
      post_q    <= LINK.post_cal_enable;
      res_q     <= LINK.resolution_select;
      CHANNEL_O <= LINK.channel_select;
    end
  end

  // ==========================================================
  // conversion sequencer
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state  <= acs_pkg::ST_IDLE;
      ph_cnt <= '0;
    end else if (LINK.converter_reset) begin
      state  <= acs_pkg::ST_IDLE;
      ph_cnt <= '0;
    end else if (start_q) begin
      state  <= acs_pkg::ST_SAMPLE;
      ph_cnt <= '0;
    end else if (tick) begin
      unique case (state)
        acs_pkg::ST_IDLE: begin
          ph_cnt <= '0;
        end
        acs_pkg::ST_SAMPLE: begin
          if (sample_end) begin
            state  <= acs_pkg::ST_DIST;
            ph_cnt <= '0;
          end else begin
            ph_cnt <= ph_cnt + 1'b1;
          end
        end
        acs_pkg::ST_DIST: begin
          if (dist_end) begin
            state  <= post_q ? acs_pkg::ST_POST : acs_pkg::ST_IDLE;
            ph_cnt <= '0;
          end else begin
            ph_cnt <= ph_cnt + 1'b1;
          end
        end
        acs_pkg::ST_POST: begin
          if (post_end) begin
            state  <= acs_pkg::ST_IDLE;
            ph_cnt <= '0;
          end else begin
            ph_cnt <= ph_cnt + 1'b1;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // sample and hold capture
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      held <= '0;
    end else if (run && (state == acs_pkg::ST_SAMPLE) && sample_end) begin
      held <= SAMPLE_VALUE_I;
    end
  end

  // ==========================================================
  // result and ready
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      result_ready <= 1'b0;
      result       <= '0;
    end else if (LINK.converter_reset || start_q) begin
      result_ready <= 1'b0;
    end else if (done) begin
      result_ready <= 1'b1;
      result       <= held & acs_pkg::res_mask(res_q);
    end
  end

  // ==========================================================
  // power-up calibration
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cal_busy <= 1'b1;
      cal_cnt  <= '0;
    end else if (LINK.converter_reset) begin
      cal_busy <= 1'b1;
      cal_cnt  <= '0;
    end else if (cal_busy && tick) begin
      if (cal_cnt == 16'(CAL_CYCLES - 1)) begin
        cal_busy <= 1'b0;
      end else begin
        cal_cnt <= cal_cnt + 1'b1;
      end
    end
  end

  // ==========================================================
  // trim array: rotating slot, offset then each bit
  assign trim_step_en = (cal_busy && tick && !LINK.converter_reset) ||
                        (done && (state == acs_pkg::ST_POST));

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      slot <= '0;
      for (int i = 0; i < acs_pkg::CAL_SLOTS; i++) begin
        trim[i] <= acs_pkg::TRIM_RESET;
      end
    end else if (trim_step_en) begin
      trim[slot] <= trim_step(trim[slot], CAL_CMP_I);
      slot       <= next_slot(slot);
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      CAL_TRIM_O <= acs_pkg::TRIM_RESET;
    end else begin
      CAL_TRIM_O <= trim[slot];
    end
  end

  // ==========================================================
  // link outputs
  assign LINK.sampling     = (state == acs_pkg::ST_SAMPLE);
  assign LINK.busy         = (state != acs_pkg::ST_IDLE);
  assign LINK.result_ready = result_ready;
  assign LINK.result       = result;
  assign LINK.calibrating  = cal_busy;

endmodule

/* File: verilog/acs_host.sv */
module acs_host (
  // clock and reset
  input  wire logic        CORE_CLK_I,
  input  wire logic        RESET_N_I,
  // axi write address
  input  wire logic [7:0]  S_AXI_AWADDR_I,
  input  wire logic        S_AXI_AWVALID_I,
  output logic             S_AXI_AWREADY_O,
  // axi write data
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  input  wire logic        S_AXI_WVALID_I,
  output logic             S_AXI_WREADY_O,
  // axi write response
  output logic [1:0]       S_AXI_BRESP_O,
  output logic             S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  // axi read address
  input  wire logic [7:0]  S_AXI_ARADDR_I,
  input  wire logic        S_AXI_ARVALID_I,
  output logic             S_AXI_ARREADY_O,
  // axi read data
  output logic [31:0]      S_AXI_RDATA_O,
  output logic [1:0]       S_AXI_RRESP_O,
  output logic             S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  // link to converter
  acs_if.usr               LINK
);

  // ==========================================================
  // declarations
  logic                         aw_full;
  logic [7:0]                   aw_addr;
  logic                         w_full;
  logic [31:0]                  w_data;
  logic [3:0]                   w_strb;
  logic                         do_write;
  logic                         do_read;
  logic                         start;
  logic [1:0]                   gap;
  logic                         conv_reset;
  logic [1:0]                   res_sel;
  logic                         post_en;
  logic [acs_pkg::CHAN_W-1:0]   channel;
  logic [acs_pkg::STC_W-1:0]    sample_time_setting;
  logic                         rdy_q;
  logic                         fresh;
  logic [acs_pkg::RESULT_W-1:0] res_cap;
  logic [31:0]                  next_rdata;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == acs_pkg::REG_CTRL) || (a == acs_pkg::REG_CFG) || (a == acs_pkg::REG_STC) ||
                (a == acs_pkg::REG_STATUS) || (a == acs_pkg::REG_RESULT);
  endfunction

  // ==========================================================
  // axi write channels
  assign S_AXI_AWREADY_O = !aw_full;
  assign S_AXI_WREADY_O  = !w_full;
  assign do_write        = aw_full && w_full && !S_AXI_BVALID_O;

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      aw_full        <= 1'b0;
      aw_addr        <= '0;
      w_full         <= 1'b0;
      w_data         <= '0;
      w_strb         <= '0;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O  <= acs_pkg::RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID_I && !aw_full) begin
        aw_full <= 1'b1;
        aw_addr <= {S_AXI_AWADDR_I[7:2], 2'b00};
      end
      if (S_AXI_WVALID_I && !w_full) begin
        w_full <= 1'b1;
        w_data <= S_AXI_WDATA_I;
        w_strb <= S_AXI_WSTRB_I;
      end
      if (do_write) begin
        aw_full        <= 1'b0;
        w_full         <= 1'b0;
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O  <= is_mapped(aw_addr) ? acs_pkg::RESP_OKAY : acs_pkg::RESP_SLVERR;
      end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
      end
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      conv_reset <= 1'b0;
      res_sel    <= acs_pkg::CFG_RES_RESET;
      post_en    <= acs_pkg::CFG_POST_RESET;
      channel    <= '0;
      sample_time_setting        <= acs_pkg::STC_RESET;
    end else if (do_write) begin
      if (aw_addr == acs_pkg::REG_CTRL && w_strb[0]) begin
        conv_reset <= w_data[acs_pkg::CTRL_CRST_BIT];
      end
      if (aw_addr == acs_pkg::REG_CFG && w_strb[0]) begin
        res_sel <= w_data[acs_pkg::CFG_RES_LSB +: 2];
        post_en <= w_data[acs_pkg::CFG_POST_BIT];
      end
      if (aw_addr == acs_pkg::REG_CFG && w_strb[1]) begin
        channel <= w_data[acs_pkg::CFG_CHAN_LSB +: acs_pkg::CHAN_W];
      end
      if (aw_addr == acs_pkg::REG_STC && w_strb[0]) begin
        sample_time_setting <= w_data[acs_pkg::STC_W-1:0];
      end
    end
  end

  // ==========================================================
  // start pulse with spacing guard
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      start <= 1'b0;
      gap   <= '0;
    end else if (do_write && aw_addr == acs_pkg::REG_CTRL && w_strb[0] &&
                 w_data[acs_pkg::CTRL_START_BIT] && gap == 2'h0) begin
      start <= 1'b1;
      gap   <= 2'(acs_pkg::START_GAP - 1);
    end else begin
      start <= 1'b0;
      gap   <= (gap == 2'h0) ? gap : gap - 1'b1;
    end
  end

  // ==========================================================
  // result capture on ready rise
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rdy_q   <= 1'b0;
      fresh   <= 1'b0;
      res_cap <= '0;
    end else begin
      rdy_q <= LINK.result_ready;
      if (LINK.result_ready && !rdy_q) begin
        res_cap <= LINK.result;
        fresh   <= 1'b1;
      end else if (do_read && {S_AXI_ARADDR_I[7:2], 2'b00} == acs_pkg::REG_RESULT) begin
        fresh <= 1'b0;
      end
    end
  end

  // ==========================================================
  // axi read channels
  assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;
  assign do_read         = S_AXI_ARVALID_I && !S_AXI_RVALID_O;

  always_comb begin
    next_rdata = '0;
    case ({S_AXI_ARADDR_I[7:2], 2'b00})
      acs_pkg::REG_CTRL: begin
        next_rdata[acs_pkg::CTRL_CRST_BIT] = conv_reset;
      end
      acs_pkg::REG_CFG: begin
        next_rdata[acs_pkg::CFG_RES_LSB +: 2]              = res_sel;
        next_rdata[acs_pkg::CFG_POST_BIT]                  = post_en;
        next_rdata[acs_pkg::CFG_CHAN_LSB +: acs_pkg::CHAN_W] = channel;
      end
      acs_pkg::REG_STC: begin
        next_rdata[acs_pkg::STC_W-1:0] = sample_time_setting;
      end
      acs_pkg::REG_STATUS: begin
        next_rdata[acs_pkg::ST_SAMPLE_BIT] = LINK.sampling;
        next_rdata[acs_pkg::ST_BUSY_BIT]   = LINK.busy;
        next_rdata[acs_pkg::ST_READY_BIT]  = LINK.result_ready;
        next_rdata[acs_pkg::ST_CAL_BIT]    = LINK.calibrating;
        next_rdata[acs_pkg::ST_FRESH_BIT]  = fresh;
      end
      acs_pkg::REG_RESULT: begin
        next_rdata[acs_pkg::RESULT_W-1:0] = res_cap;
        next_rdata[acs_pkg::RES_FRESH_BIT] = fresh;
      end
      default: begin
        next_rdata = '0;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O  <= '0;
      S_AXI_RRESP_O  <= acs_pkg::RESP_OKAY;
    end else if (do_read) begin
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RDATA_O  <= next_rdata;
      S_AXI_RRESP_O  <= is_mapped({S_AXI_ARADDR_I[7:2], 2'b00}) ? acs_pkg::RESP_OKAY
                                                               : acs_pkg::RESP_SLVERR;
    end else if (S_AXI_RREADY_I) begin
      S_AXI_RVALID_O <= 1'b0;
    end
  end

  // ==========================================================
  // link outputs
  assign LINK.conversion_start  = start;
  assign LINK.channel_select    = channel;
  assign LINK.sample_time_field = sample_time_setting;
  assign LINK.post_cal_enable   = post_en;
  assign LINK.resolution_select = res_sel;
  assign LINK.converter_reset   = conv_reset;

endmodule

/* File: dv/acs_chk.sv */
module acs_chk #(
  parameter int CAL_CYCLES = acs_pkg::CAL_CYCLES,
  parameter int CONV_DIV   = acs_pkg::CONV_DIV
) (
  // clock and reset
  input wire logic                         CORE_CLK_I,
  input wire logic                         RESET_N_I,
  // link signals
  input wire logic                         conversion_start,
  input wire logic [acs_pkg::STC_W-1:0]    sample_time_field,
  input wire logic                         post_cal_enable,
  input wire logic [1:0]                   resolution_select,
  input wire logic                         converter_reset,
  input wire logic                         sampling,
  input wire logic                         busy,
  input wire logic                         result_ready,
  input wire logic [acs_pkg::RESULT_W-1:0] result,
  input wire logic                         calibrating
);
  // ==========================================================
  // helper counters
  logic        st1;
  logic [11:0] bcnt;
  logic [15:0] ccnt;
  int          nb;
  assign nb = resolution_select == 2'h0 ? 8 : resolution_select == 2'h1 ? 10 : 12;
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) st1 <= 1'b0;
    else st1 <= conversion_start;
  end
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) bcnt <= 12'h000;
    else if (st1) bcnt <= 12'h001;
    else if (busy) bcnt <= bcnt + 12'h001;
  end
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) ccnt <= 16'h0000;
    else if (converter_reset) ccnt <= 16'h0000;
    else if (calibrating) ccnt <= ccnt + 16'h0001;
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  sequence s_go;
    sampling && busy && !result_ready;
  endsequence
  sequence s_done;
    !busy && result_ready;
  endsequence
  chk_start_pulse: assert property (conversion_start |=> !conversion_start)
    else $error("start pulse longer than one cycle");
  chk_start_go: assert property (conversion_start && !converter_reset |-> ##2 s_go)
    else $error("start did not raise sampling and busy");
  chk_sample_busy: assert property (sampling |-> busy)
    else $error("sampling without busy");
  chk_sample_len: assert property ($fell(sampling) && !converter_reset |->
    bcnt == CONV_DIV * (sample_time_field + 1) + 1)
    else $error("sample phase length wrong");
  chk_conv_len: assert property ($fell(busy) && !converter_reset |->
    bcnt == CONV_DIV * (sample_time_field + 1 + nb + 2 * post_cal_enable) + 1)
    else $error("conversion length wrong");
  chk_ready_rise: assert property ($fell(busy) && !converter_reset |-> s_done)
    else $error("ready not raised as busy fell");
  chk_ready_hold: assert property ($fell(result_ready) |->
    $past(conversion_start, 2) || $past(converter_reset) || $past(converter_reset, 2))
    else $error("ready fell without a start");
  chk_result_hold: assert property (!$rose(result_ready) |-> $stable(result))
    else $error("result changed outside ready rise");
  chk_cal_len: assert property ($fell(calibrating) |->
    ccnt inside {[CAL_CYCLES * CONV_DIV - CONV_DIV : CAL_CYCLES * CONV_DIV + CONV_DIV]})
    else $error("calibration length wrong");
  chk_cal_hold: assert property (converter_reset ##1 converter_reset |-> calibrating)
    else $error("calibrating low in converter reset");
endmodule

/* File: dv/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // signals
  logic        clk = 1'b0, rst_n = 1'b0, cmp = 1'b0, rdy_seen = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, trim_o;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [11:0] sval = 12'h000;
  logic [4:0]  chan_o;
  logic [33:0] exp_rd[$];
  logic [11:0] exp_res[$];
  logic [1:0]  exp_b[$];
  int          fails = 0, total_checks = 0, cycles = 0;
  integer      seed = 32'hc1de;
  acs_if link();
  acs_host acs_host_inst(.CORE_CLK_I(clk), .RESET_N_I(rst_n), .S_AXI_AWADDR_I(awaddr),
    .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF),
    .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .LINK(link));
  acs_device #(.CAL_CYCLES(8), .CONV_DIV(2)) acs_device_inst(.CORE_CLK_I(clk), .RESET_N_I(rst_n), .LINK(link),
    .SAMPLE_VALUE_I(sval), .CAL_CMP_I(cmp), .CHANNEL_O(chan_o), .CAL_TRIM_O(trim_o));
  acs_chk #(.CAL_CYCLES(8), .CONV_DIV(2)) acs_chk_inst(.CORE_CLK_I(clk), .RESET_N_I(rst_n),
    .conversion_start(link.conversion_start), .sample_time_field(link.sample_time_field),
    .post_cal_enable(link.post_cal_enable), .resolution_select(link.resolution_select),
    .converter_reset(link.converter_reset), .sampling(link.sampling), .busy(link.busy),
    .result_ready(link.result_ready), .result(link.result), .calibrating(link.calibrating));
  always #2 clk = ~clk;
  // ==========================================================
  // checking and closing
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (fails == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(negedge clk) begin
    if (bvalid && bready) check(bresp, exp_b.pop_front());
    if (rvalid && rready) check({rresp, rdata}, exp_rd.pop_front());
    if (link.result_ready && !rdy_seen) check(link.result, exp_res.pop_front());
    rdy_seen = link.result_ready;
  end
  always @(posedge clk) begin
    cmp <= $random(seed);
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails++;
      test_done;
    end
  end
  // ==========================================================
  // bus tasks
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_t, w_t, b_t;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    exp_b.push_back(er);
    do begin
      @(negedge clk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid;
      @(posedge clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end while (!b_t);
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, input logic [33:0] e);
    logic ar_t, r_t;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    exp_rd.push_back(e);
    do begin
      @(negedge clk);
      ar_t = arvalid && arready;
      r_t = rvalid;
      @(posedge clk);
      if (ar_t) arvalid <= 1'b0;
    end while (!r_t);
    rready <= 1'b0;
  endtask
  task automatic conv(input logic [1:0] res, input logic post, input logic [7:0] sample_time_setting, input logic ab);
    logic [4:0] ch;
    logic [11:0] v, m;
    ch = $random(seed);
    v = $random(seed);
    m = 12'hFFF << (res == 2'h0 ? 4 : res == 2'h1 ? 2 : 0);
    axw(8'h08, {24'h0, sample_time_setting}, 2'h0);
    axw(8'h04, {19'h0, ch, 4'h0, post, 1'b0, res}, 2'h0);
    sval <= ab ? ~v : v;
    exp_res.push_back(v & m);
    axw(8'h00, 32'h1, 2'h0);
    if (ab) begin
      sval <= v;
      axw(8'h00, 32'h1, 2'h0);
    end
    repeat (3) @(posedge clk);
    for (int k = 0; k < 3000 && !link.result_ready; k++) @(posedge clk);
    check(chan_o, ch);
    axr(8'h10, {18'h1, 4'h0, v & m});
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    check(trim_o, 8'h80);
    rst_n <= 1'b1;
    axr(8'h0C, 34'h8);
    axr(8'h04, 34'hA);
    axr(8'h08, 34'h4);
    axr(8'h14, {2'h2, 32'h0});
    axw(8'h14, 32'h0, 2'h2);
    for (int k = 0; k < 2000 && link.calibrating; k++) @(posedge clk);
    check(link.calibrating, 1'b0);
    for (int i = 0; i < 6; i++) conv(i % 3, i / 3, i == 0 ? 8'h00 : i == 5 ? 8'hFF : 8'($random(seed) & 15), 1'b0);
    conv(2'h1, 1'b1, 8'h20, 1'b1);
    axw(8'h00, 32'h2, 2'h0);
    repeat (4) @(posedge clk);
    axr(8'h0C, 34'h8);
    axw(8'h00, 32'h0, 2'h0);
    for (int k = 0; k < 2000 && link.calibrating; k++) @(posedge clk);
    check(link.calibrating, 1'b0);
    conv(2'h3, 1'b1, 8'h03, 1'b0);
    test_done;
  end
endmodule
